// ==== rtl/sdhtx_pkg.sv ====
`default_nettype none
package sdhtx_pkg;

	// ********************************
	// Register map
	// ********************************
	localparam logic [7:0] ADDR_OH_MISC = 8'h15;
	localparam logic [7:0] ADDR_OFS_HI = 8'h16;
	localparam logic [7:0] ADDR_OFS_LO = 8'h17;
	localparam logic [7:0] ADDR_SBIT_EXP = 8'h1d;
	localparam logic [7:0] ADDR_C1_VAL = 8'h1e;
	localparam logic [7:0] ADDR_C2_EXP = 8'h1f;
	localparam logic [7:0] ADDR_MODE = 8'h20;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h21;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h22;
	localparam logic [7:0] REG_RESET = 8'h00;

	// ********************************
	// Field positions
	// ********************************
	localparam int MISC_SBIT_OFF = 4;
	localparam int MISC_SBIT_SEL = 3;
	localparam int MISC_ZERO = 2;
	localparam int MISC_C2_FIX_OFF = 1;
	localparam int MISC_SW_C1 = 0;
	localparam int HI_DELAY = 3;
	localparam int HI_AIS = 0;
	localparam int MODE_TOH_GEN = 0;
	localparam int MODE_POH_OFF = 1;
	localparam int MODE_TIMING = 2;
	localparam int IRQ_FRAME = 0;
	localparam int IRQ_SBIT = 1;
	localparam int IRQ_C2 = 2;
	localparam int IRQ_W = 3;

	// ********************************
	// Frame geometry and byte values
	// ********************************
	localparam logic [11:0] FRAME_LAST = 12'd2429;
	localparam logic [11:0] OFS_MAX = 12'd2429;
	localparam logic [11:0] FRAME_LEN = 12'd2430;
	localparam logic [8:0] ROW_LEN = 9'd270;
	localparam logic [8:0] TOH_COLS = 9'd9;
	localparam logic [11:0] C11_POS = 12'd6;
	localparam logic [11:0] A2_POS = 12'd3;
	localparam logic [7:0] C1_FIXED = 8'h01;
	localparam logic [7:0] C2_FIXED = 8'h01;
	localparam logic [1:0] SBIT_FIXED = 2'h2;
	localparam logic [7:0] A1_VAL = 8'hf6;
	localparam logic [7:0] A2_VAL = 8'h28;
	localparam logic [7:0] AIS_BYTE = 8'hff;
	localparam logic [7:0] ZERO_BYTE = 8'h00;

	typedef enum logic [2:0] {
		SDHTX_TM_DROP = 3'h1,
		SDHTX_TM_ADD = 3'h2,
		SDHTX_TM_EXT = 3'h4
	} sdhtx_timing_t;

	function automatic sdhtx_timing_t sdhtx_timing(input logic [1:0] f);
		case (f)
			2'h1: sdhtx_timing = SDHTX_TM_ADD;
			2'h2: sdhtx_timing = SDHTX_TM_EXT;
			default: sdhtx_timing = SDHTX_TM_DROP;
		endcase
	endfunction

endpackage
`default_nettype wire

// ==== rtl/sdhtx_frame_ctr.sv ====
`default_nettype none
module sdhtx_frame_ctr (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Frame reference
	input wire logic ext_frame_pulse_in,
	input wire logic comp_en,
	input wire logic [11:0] offset,
	// Position
	output logic [11:0] pos,
	output logic [8:0] col,
	output logic frame_start
);
	import sdhtx_pkg::*;

	typedef struct packed {
		logic [11:0] pos;
		logic [8:0] col;
		logic start;
	} sdhtx_ctr_t;

	sdhtx_ctr_t st, next_st;
	logic [11:0] eff_ofs;
	logic [12:0] load_sum;
	logic [11:0] load_pos;

	// Column by repeated subtraction; nine rows at most
	function automatic logic [8:0] col_of(input logic [11:0] p);
		logic [11:0] r;
		r = p;
		for (int i = 0; i < 8; i++) begin
			if (r >= {3'h0, ROW_LEN})
				r = r - {3'h0, ROW_LEN};
		end
		col_of = r[8:0];
	endfunction

	always_comb begin
		eff_ofs = 12'h000;
		if (comp_en && offset <= OFS_MAX)
			eff_ofs = offset;
		load_sum = {1'b0, C11_POS} + {1'b0, eff_ofs};
		if (load_sum > {1'b0, FRAME_LAST})
			load_pos = 12'(load_sum - {1'b0, FRAME_LEN});
		else
			load_pos = load_sum[11:0];
		next_st = st;
		next_st.start = 1'b0;
		if (ext_frame_pulse_in) begin
			// Pulse marks C11 plus the late offset, so the frame began earlier
			next_st.pos = load_pos;
			next_st.col = col_of(load_pos);
		end else if (st.pos == FRAME_LAST) begin
			next_st.pos = 12'h000;
			next_st.col = 9'h000;
			next_st.start = 1'b1;
		end else begin
			next_st.pos = st.pos + 12'h001;
			next_st.col = (st.col == ROW_LEN - 9'h001) ? 9'h000 : st.col + 9'h001;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst)
			st <= '0;
		else
			st <= next_st;
	end

	assign pos = st.pos;
	assign col = st.col;
	assign frame_start = st.start;

	property p_pulse_load;
		@(posedge sys_clk) disable iff (rst)
		ext_frame_pulse_in && comp_en && offset == 12'h001 |=> pos == C11_POS + 12'h001;
	endproperty
	a_pulse_load: assert property (p_pulse_load) else $error("offset 1 not at second C1");

	property p_big_ofs;
		@(posedge sys_clk) disable iff (rst)
		ext_frame_pulse_in && (offset > OFS_MAX || !comp_en) |=> pos == C11_POS;
	endproperty
	a_big_ofs: assert property (p_big_ofs) else $error("offset not zeroed");

endmodule
`default_nettype wire

// ==== rtl/sdhtx_tx_mux.sv ====
`default_nettype none
module sdhtx_tx_mux (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Position
	input wire logic [11:0] pos,
	input wire logic [8:0] col,
	// Mapped stream
	input wire logic [7:0] mapped_byte,
	input wire logic mapped_is_poh,
	// Controls
	input wire logic toh_gen,
	input wire logic path_oh_insert_off,
	input wire logic unused_bytes_zero,
	input wire logic path_alarm_gen_on,
	input wire logic sw_c1_value_sel,
	input wire logic [7:0] sw_c1_value,
	// Add bus byte
	output logic [7:0] tx_byte,
	output logic tx_byte_oe
);
	import sdhtx_pkg::*;

	typedef struct packed {
		logic [7:0] data;
		logic oe;
	} sdhtx_mux_t;

	sdhtx_mux_t st, next_st;
	logic is_toh;
	logic gen_pos;

	always_comb begin
		is_toh = col < TOH_COLS;
		gen_pos = toh_gen && pos <= C11_POS;
		next_st.data = mapped_byte;
		next_st.oe = 1'b1;
		if (is_toh) begin
			if (gen_pos) begin
				if (pos == C11_POS)
					next_st.data = sw_c1_value_sel ? sw_c1_value : C1_FIXED;
				else
					next_st.data = (pos < A2_POS) ? A1_VAL : A2_VAL;
				if (path_alarm_gen_on)
					next_st.data = AIS_BYTE;
			end else begin
				next_st.data = ZERO_BYTE;
				next_st.oe = unused_bytes_zero;
			end
		end else if (path_alarm_gen_on && path_oh_insert_off) begin
			next_st.data = AIS_BYTE;
		end else if (mapped_is_poh && path_oh_insert_off) begin
			next_st.data = ZERO_BYTE;
			next_st.oe = unused_bytes_zero;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst)
			st <= '0;
		else
			st <= next_st;
	end

	assign tx_byte = st.data;
	assign tx_byte_oe = st.oe;

	property p_ais;
		@(posedge sys_clk) disable iff (rst)
		path_alarm_gen_on && path_oh_insert_off && col >= TOH_COLS |=> tx_byte == AIS_BYTE;
	endproperty
	a_ais: assert property (p_ais) else $error("path AIS not all ones");

	property p_unused;
		@(posedge sys_clk) disable iff (rst)
		col < TOH_COLS && !toh_gen |=> tx_byte_oe == $past(unused_bytes_zero) && tx_byte == 8'h00;
	endproperty
	a_unused: assert property (p_unused) else $error("unused byte drive wrong");

	property p_c1;
		@(posedge sys_clk) disable iff (rst)
		toh_gen && pos == C11_POS && !path_alarm_gen_on && !sw_c1_value_sel
			|=> tx_byte == C1_FIXED;
	endproperty
	a_c1: assert property (p_c1) else $error("fixed C1 not sent");

	property p_normal;
		@(posedge sys_clk) disable iff (rst)
		!path_alarm_gen_on && col >= TOH_COLS && !mapped_is_poh
			|=> tx_byte == $past(mapped_byte);
	endproperty
	a_normal: assert property (p_normal) else $error("payload altered");

endmodule
`default_nettype wire

// ==== rtl/sdhtx_oh_ctrl.sv ====
// The address-and-strobe port was chosen for this implementation.
`default_nettype none
module sdhtx_oh_ctrl (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	output logic irq,
	// Pins
	input wire logic ptr_tracker_enable_pin,
	input wire logic ext_timing_enable_pin,
	input wire logic ext_frame_pulse_in,
	// Receive side
	input wire logic [7:0] rx_byte,
	input wire logic rx_h1_valid,
	input wire logic rx_c2_valid,
	output logic sbit_mismatch,
	output logic c2_mismatch,
	// Transmit side
	input wire logic [7:0] mapped_byte,
	input wire logic mapped_is_poh,
	output logic [7:0] tx_byte,
	output logic tx_byte_oe,
	output logic tx_frame_start
);
	import sdhtx_pkg::*;

	typedef struct packed {
		logic [7:0] misc;
		logic [7:0] ofs_hi;
		logic [7:0] ofs_lo;
		logic [1:0] sbit_exp;
		logic [7:0] c1_val;
		logic [7:0] c2_exp;
		logic [7:0] mode;
		logic [IRQ_W-1:0] irq_stat;
		logic [IRQ_W-1:0] irq_mask;
		logic [7:0] rdata;
		logic sbit_mis;
		logic c2_mis;
	} sdhtx_state_t;

	sdhtx_state_t st, next_st;
	sdhtx_timing_t timing;
	logic [11:0] offset;
	logic comp_en;
	logic toh_gen;
	logic sbit_chk;
	logic [1:0] sbit_ref;
	logic sbit_bad;
	logic c2_bad;
	logic [IRQ_W-1:0] events;
	logic frame_start;
	logic [11:0] pos;
	logic [8:0] col;

	// ********************************
	// Control decode
	// ********************************
	always_comb begin
		timing = sdhtx_timing(st.mode[MODE_TIMING +: 2]);
		offset = {st.ofs_hi[7:4], st.ofs_lo};
		comp_en = st.ofs_hi[HI_DELAY] && ext_timing_enable_pin && timing == SDHTX_TM_EXT;
		// Generation exists only in drop or external timing
		toh_gen = st.mode[MODE_TOH_GEN] && timing != SDHTX_TM_ADD;
		sbit_chk = ptr_tracker_enable_pin && !st.misc[MISC_SBIT_OFF];
		sbit_ref = st.misc[MISC_SBIT_SEL] ? st.sbit_exp : SBIT_FIXED;
		sbit_bad = rx_h1_valid && sbit_chk && rx_byte[3:2] != sbit_ref;
		// Either match clears the alarm unless the fixed compare is off
		c2_bad = rx_c2_valid && rx_byte != st.c2_exp
			&& (st.misc[MISC_C2_FIX_OFF] || rx_byte != C2_FIXED);
		events = '0;
		events[IRQ_FRAME] = frame_start;
		events[IRQ_SBIT] = sbit_bad;
		events[IRQ_C2] = c2_bad;
	end

	// ********************************
	// Register file and alarms
	// ********************************
	always_comb begin
		next_st = st;
		next_st.rdata = 8'h00;
		if (rx_h1_valid)
			next_st.sbit_mis = sbit_bad;
		if (rx_c2_valid)
			next_st.c2_mis = c2_bad;
		if (reg_wr) begin
			case (reg_addr)
				ADDR_OH_MISC: next_st.misc = reg_wdata;
				ADDR_OFS_HI: next_st.ofs_hi = reg_wdata;
				ADDR_OFS_LO: next_st.ofs_lo = reg_wdata;
				ADDR_SBIT_EXP: next_st.sbit_exp = reg_wdata[1:0];
				ADDR_C1_VAL: next_st.c1_val = reg_wdata;
				ADDR_C2_EXP: next_st.c2_exp = reg_wdata;
				ADDR_MODE: next_st.mode = reg_wdata;
				ADDR_IRQ_MASK: next_st.irq_mask = reg_wdata[IRQ_W-1:0];
				default: next_st.rdata = 8'h00;
			endcase
		end
		if (reg_rd) begin
			case (reg_addr)
				ADDR_OH_MISC: next_st.rdata = st.misc;
				ADDR_OFS_HI: next_st.rdata = st.ofs_hi;
				ADDR_OFS_LO: next_st.rdata = st.ofs_lo;
				ADDR_SBIT_EXP: next_st.rdata = {6'h00, st.sbit_exp};
				ADDR_C1_VAL: next_st.rdata = st.c1_val;
				ADDR_C2_EXP: next_st.rdata = st.c2_exp;
				ADDR_MODE: next_st.rdata = st.mode;
				ADDR_IRQ_STAT: begin
					next_st.rdata = {5'h00, st.irq_stat};
					next_st.irq_stat = '0;
				end
				ADDR_IRQ_MASK: next_st.rdata = {5'h00, st.irq_mask};
				default: next_st.rdata = 8'h00;
			endcase
		end
		// New events win over the read clear
		next_st.irq_stat = next_st.irq_stat | events;
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			st <= '0;
			st.misc <= REG_RESET;
			st.mode <= REG_RESET;
		end else begin
			st <= next_st;
		end
	end

	assign reg_rdata = st.rdata;
	assign irq = |(st.irq_stat & st.irq_mask);
	assign sbit_mismatch = st.sbit_mis;
	assign c2_mismatch = st.c2_mis;
	assign tx_frame_start = frame_start;

	// ********************************
	// Transmit timing and byte mux
	// ********************************
	sdhtx_frame_ctr u_ctr (
		.sys_clk(sys_clk),
		.rst(rst),
		.ext_frame_pulse_in(ext_frame_pulse_in),
		.comp_en(comp_en),
		.offset(offset),
		.pos(pos),
		.col(col),
		.frame_start(frame_start)
	);

	sdhtx_tx_mux u_mux (
		.sys_clk(sys_clk),
		.rst(rst),
		.pos(pos),
		.col(col),
		.mapped_byte(mapped_byte),
		.mapped_is_poh(mapped_is_poh),
		.toh_gen(toh_gen),
		.path_oh_insert_off(st.mode[MODE_POH_OFF]),
		.unused_bytes_zero(st.misc[MISC_ZERO]),
		.path_alarm_gen_on(st.ofs_hi[HI_AIS]),
		.sw_c1_value_sel(st.misc[MISC_SW_C1]),
		.sw_c1_value(st.c1_val),
		.tx_byte(tx_byte),
		.tx_byte_oe(tx_byte_oe)
	);

	// ********************************
	// Checks
	// ********************************
	property p_sbit_gate;
		@(posedge sys_clk) disable iff (rst)
		rx_h1_valid && !ptr_tracker_enable_pin |=> !sbit_mismatch;
	endproperty
	a_sbit_gate: assert property (p_sbit_gate) else $error("S-bit check without tracker");

	property p_sbit_fixed;
		@(posedge sys_clk) disable iff (rst)
		rx_h1_valid && ptr_tracker_enable_pin && !st.misc[MISC_SBIT_OFF]
			&& !st.misc[MISC_SBIT_SEL] |=> sbit_mismatch == ($past(rx_byte[3:2]) != 2'h2);
	endproperty
	a_sbit_fixed: assert property (p_sbit_fixed) else $error("S-bit fixed compare wrong");

	property p_c2_only_sw;
		@(posedge sys_clk) disable iff (rst)
		rx_c2_valid && st.misc[MISC_C2_FIX_OFF] && rx_byte == 8'h01 && st.c2_exp != 8'h01
			|=> c2_mismatch;
	endproperty
	a_c2_only_sw: assert property (p_c2_only_sw) else $error("fixed C2 still accepted");

	property p_ofs_split;
		@(posedge sys_clk) disable iff (rst)
		reg_wr && reg_addr == ADDR_OFS_LO |=> offset[7:0] == $past(reg_wdata);
	endproperty
	a_ofs_split: assert property (p_ofs_split) else $error("offset low byte wrong");

	property p_irq_sticky;
		@(posedge sys_clk) disable iff (rst)
		c2_bad && st.irq_mask[IRQ_C2] |=> irq && st.irq_stat[IRQ_C2];
	endproperty
	a_irq_sticky: assert property (p_irq_sticky) else $error("interrupt not raised");

	property p_sbit_off;
		@(posedge sys_clk) disable iff (rst)
		rx_h1_valid && st.misc[MISC_SBIT_OFF] |=> !sbit_mismatch;
	endproperty
	a_sbit_off: assert property (p_sbit_off) else $error("S-bit checked while off");

	property p_sbit_sw;
		@(posedge sys_clk) disable iff (rst)
		rx_h1_valid && ptr_tracker_enable_pin && !st.misc[MISC_SBIT_OFF]
			&& st.misc[MISC_SBIT_SEL]
			|=> sbit_mismatch == ($past(rx_byte[3:2]) != $past(st.sbit_exp));
	endproperty
	a_sbit_sw: assert property (p_sbit_sw) else $error("S-bit software compare wrong");

	property p_sbit_hold;
		@(posedge sys_clk) disable iff (rst)
		!rx_h1_valid |=> $stable(sbit_mismatch);
	endproperty
	a_sbit_hold: assert property (p_sbit_hold) else $error("S-bit result moved without H1");

	property p_c2_fixed_ok;
		@(posedge sys_clk) disable iff (rst)
		rx_c2_valid && !st.misc[MISC_C2_FIX_OFF] && rx_byte == C2_FIXED |=> !c2_mismatch;
	endproperty
	a_c2_fixed_ok: assert property (p_c2_fixed_ok) else $error("fixed C2 rejected");

	property p_c2_sw_ok;
		@(posedge sys_clk) disable iff (rst)
		rx_c2_valid && rx_byte == st.c2_exp |=> !c2_mismatch;
	endproperty
	a_c2_sw_ok: assert property (p_c2_sw_ok) else $error("expected C2 rejected");

	property p_c2_bad;
		@(posedge sys_clk) disable iff (rst)
		rx_c2_valid && rx_byte != st.c2_exp && rx_byte != C2_FIXED |=> c2_mismatch;
	endproperty
	a_c2_bad: assert property (p_c2_bad) else $error("C2 mismatch missed");

	property p_comp_pin;
		@(posedge sys_clk) disable iff (rst)
		!ext_timing_enable_pin |-> !comp_en;
	endproperty
	a_comp_pin: assert property (p_comp_pin) else $error("offset used with pin low");

	property p_comp_mode;
		@(posedge sys_clk) disable iff (rst)
		st.mode[MODE_TIMING +: 2] != 2'h2 |-> !comp_en;
	endproperty
	a_comp_mode: assert property (p_comp_mode) else $error("offset used off ext timing");

	property p_ofs_hi;
		@(posedge sys_clk) disable iff (rst)
		reg_wr && reg_addr == ADDR_OFS_HI |=> offset[11:8] == $past(reg_wdata[7:4]);
	endproperty
	a_ofs_hi: assert property (p_ofs_hi) else $error("offset top nibble wrong");

	property p_toh_add;
		@(posedge sys_clk) disable iff (rst)
		st.mode[MODE_TIMING +: 2] == 2'h1 |-> !toh_gen;
	endproperty
	a_toh_add: assert property (p_toh_add) else $error("overhead made in add timing");

	property p_rdata_idle;
		@(posedge sys_clk) disable iff (rst)
		!reg_rd |=> reg_rdata == 8'h00;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data without read");

	property p_unmapped;
		@(posedge sys_clk) disable iff (rst)
		reg_rd && reg_addr > ADDR_IRQ_MASK |=> reg_rdata == 8'h00;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

	property p_stat_clear;
		@(posedge sys_clk) disable iff (rst)
		reg_rd && reg_addr == ADDR_IRQ_STAT && events == '0 |=> st.irq_stat == '0;
	endproperty
	a_stat_clear: assert property (p_stat_clear) else $error("status not cleared by read");

	property p_event_wins;
		@(posedge sys_clk) disable iff (rst)
		c2_bad |=> st.irq_stat[IRQ_C2];
	endproperty
	a_event_wins: assert property (p_event_wins) else $error("C2 event lost");

	property p_irq_masked;
		@(posedge sys_clk) disable iff (rst)
		st.irq_mask == '0 |-> !irq;
	endproperty
	a_irq_masked: assert property (p_irq_masked) else $error("interrupt with all masked");

endmodule
`default_nettype wire

// ==== verification/sdhtx_far_end.sv ====
`default_nettype none
module sdhtx_far_end (
	// Clock
	input wire logic sys_clk,
	// Payload kind chosen by the bench
	input wire logic poh_sel,
	// External timing and drop side
	output logic ext_frame_pulse_in,
	output logic [7:0] rx_byte,
	output logic rx_h1_valid,
	output logic rx_c2_valid,
	// Mapped stream
	output logic [7:0] mapped_byte,
	output logic mapped_is_poh
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] rx_val = 8'h00;
	// Idle drop bus shows the inverse, so a stale byte never matches
	assign rx_byte = (rx_h1_valid | rx_c2_valid) ? rx_val : ~rx_val;
	assign mapped_byte = 8'ha5;
	assign mapped_is_poh = poh_sel;
	initial begin
		ext_frame_pulse_in = 1'b0;
		rx_h1_valid = 1'b0;
		rx_c2_valid = 1'b0;
	end
	// ********************************
	// Requests, entered just after an edge
	// ********************************
	task automatic frame_pulse();
		ext_frame_pulse_in <= 1'b1;
		@(posedge sys_clk);
		ext_frame_pulse_in <= 1'b0;
	endtask
	task automatic rx_send(input logic c2, input logic [7:0] b);
		rx_val <= b;
		rx_h1_valid <= !c2;
		rx_c2_valid <= c2;
		@(posedge sys_clk);
		rx_h1_valid <= 1'b0;
		rx_c2_valid <= 1'b0;
	endtask
endmodule
`default_nettype wire

// ==== verification/tb_sdh_tx_overhead_c1_offset_ctrl.sv ====
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin err_total++; \
	$display("FAIL %s exp %h got %h", nm, e, g); end end
module tb_sdh_tx_overhead_c1_offset_ctrl;
	timeunit 1ns;
	timeprecision 1ps;
	import sdhtx_pkg::*;
	localparam int LIMIT = 20000;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic ptr_tracker_enable_pin = 1'b0;
	logic ext_timing_enable_pin = 1'b0;
	logic poh_sel = 1'b0;
	logic [7:0] reg_rdata, rx_byte, mapped_byte, tx_byte, d;
	logic irq, ext_frame_pulse_in, rx_h1_valid, rx_c2_valid, sbit_mismatch, c2_mismatch;
	logic mapped_is_poh, tx_byte_oe, tx_frame_start;
	int err_total = 0;
	int n_checks = 0;
	int cyc = 0;
	int i;
	sdhtx_oh_ctrl dut (.sys_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.irq, .ptr_tracker_enable_pin, .ext_timing_enable_pin, .ext_frame_pulse_in, .rx_byte,
		.rx_h1_valid, .rx_c2_valid, .sbit_mismatch, .c2_mismatch, .mapped_byte,
		.mapped_is_poh, .tx_byte, .tx_byte_oe, .tx_frame_start);
	sdhtx_far_end far (.sys_clk, .poh_sel, .ext_frame_pulse_in, .rx_byte, .rx_h1_valid,
		.rx_c2_valid, .mapped_byte, .mapped_is_poh);
	initial begin
		forever #2.5 sys_clk = ~sys_clk;
	end
	task automatic close_out();
		if (err_total == 0 && n_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// Hang guard
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == LIMIT) begin
			err_total++;
			close_out();
		end
	end
	// ********************************
	// Register port, every task entered and left just after an edge
	// ********************************
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		@(posedge sys_clk);
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1;
		v = reg_rdata;
		@(posedge sys_clk);
	endtask
	task automatic rchk(input string nm, input logic [7:0] a, input logic [7:0] e);
		logic [7:0] v;
		rd(a, v);
		`CHK(nm, e, v)
	endtask
	task automatic chk_irq(input logic e);
		#1;
		`CHK("irq", e, irq)
		@(posedge sys_clk);
	endtask
	// ********************************
	// Scenarios
	// ********************************
	// Byte for position 6 + effective offset, two edges after the pulse
	task automatic tx_case(input logic [11:0] ofs, input logic [3:0] ctl, input logic [7:0] misc,
			input logic [7:0] mode, input logic pin, input logic poh, input logic [7:0] eb,
			input logic eo);
		wr(ADDR_OH_MISC, misc);
		wr(ADDR_OFS_HI, {ofs[11:8], ctl});
		wr(ADDR_OFS_LO, ofs[7:0]);
		wr(ADDR_MODE, mode);
		ext_timing_enable_pin <= pin;
		poh_sel <= poh;
		far.frame_pulse();
		@(posedge sys_clk);
		#1;
		`CHK("tx_byte_oe", eo, tx_byte_oe)
		if (eo) `CHK("tx_byte", eb, tx_byte)
		@(posedge sys_clk);
	endtask
	task automatic rx_case(input logic pin, input logic [7:0] misc, input logic [1:0] sx,
			input logic c2, input logic [7:0] b, input logic e);
		wr(ADDR_OH_MISC, misc);
		wr(ADDR_SBIT_EXP, {6'h00, sx});
		ptr_tracker_enable_pin <= pin;
		far.rx_send(c2, b);
		@(posedge sys_clk);
		#1;
		`CHK("mismatch", e, c2 ? c2_mismatch : sbit_mismatch)
		@(posedge sys_clk);
	endtask
	initial begin
		repeat (16) @(posedge sys_clk);
		rst <= 1'b0;
		rchk("misc_rst", ADDR_OH_MISC, REG_RESET);
		rchk("ofs_hi_rst", ADDR_OFS_HI, REG_RESET);
		rchk("ofs_lo_rst", ADDR_OFS_LO, REG_RESET);
		rchk("unmapped", 8'h40, 8'h00);
		wr(8'h40, 8'h77);
		rchk("unmapped_wr", 8'h40, 8'h00);
		wr(ADDR_OH_MISC, 8'h5a);
		rchk("misc_rw", ADDR_OH_MISC, 8'h5a);
		wr(ADDR_OFS_HI, 8'h9c);
		wr(ADDR_OFS_LO, 8'hc3);
		rchk("ofs_hi_rw", ADDR_OFS_HI, 8'h9c);
		rchk("ofs_lo_rw", ADDR_OFS_LO, 8'hc3);
		wr(ADDR_C1_VAL, 8'h3c);
		rchk("c1_rw", ADDR_C1_VAL, 8'h3c);
		wr(ADDR_C2_EXP, 8'h33);
		// Aligned pulse, so software keeps the offset at zero
		tx_case(12'h000, 4'h8, 8'h01, 8'h09, 1'b1, 1'b0, 8'h3c, 1'b1);
		tx_case(12'h000, 4'h8, 8'h00, 8'h09, 1'b1, 1'b0, C1_FIXED, 1'b1);
		tx_case(12'h001, 4'h8, 8'h04, 8'h09, 1'b1, 1'b0, ZERO_BYTE, 1'b1);
		tx_case(12'h001, 4'h8, 8'h00, 8'h09, 1'b1, 1'b0, ZERO_BYTE, 1'b0);
		tx_case(12'h978, 4'h8, 8'h00, 8'h09, 1'b1, 1'b0, A1_VAL, 1'b1);
		tx_case(12'h97d, 4'h8, 8'h00, 8'h09, 1'b1, 1'b0, A2_VAL, 1'b1);
		tx_case(12'h97e, 4'h8, 8'h00, 8'h09, 1'b1, 1'b0, C1_FIXED, 1'b1);
		tx_case(12'hfff, 4'h8, 8'h00, 8'h09, 1'b1, 1'b0, C1_FIXED, 1'b1);
		tx_case(12'h978, 4'h0, 8'h00, 8'h09, 1'b1, 1'b0, C1_FIXED, 1'b1);
		tx_case(12'h978, 4'h8, 8'h00, 8'h09, 1'b0, 1'b0, C1_FIXED, 1'b1);
		tx_case(12'h978, 4'h8, 8'h00, 8'h01, 1'b1, 1'b0, C1_FIXED, 1'b1);
		tx_case(12'h978, 4'h8, 8'h00, 8'h0d, 1'b1, 1'b0, C1_FIXED, 1'b1);
		tx_case(12'h000, 4'h8, 8'h05, 8'h05, 1'b1, 1'b0, ZERO_BYTE, 1'b1);
		tx_case(12'h000, 4'h9, 8'h00, 8'h09, 1'b1, 1'b0, AIS_BYTE, 1'b1);
		tx_case(12'h100, 4'h8, 8'h00, 8'h09, 1'b1, 1'b0, 8'ha5, 1'b1);
		tx_case(12'h100, 4'h9, 8'h00, 8'h0b, 1'b1, 1'b0, AIS_BYTE, 1'b1);
		tx_case(12'h100, 4'h9, 8'h00, 8'h09, 1'b1, 1'b0, 8'ha5, 1'b1);
		tx_case(12'h100, 4'h8, 8'h04, 8'h0b, 1'b1, 1'b1, ZERO_BYTE, 1'b1);
		tx_case(12'h100, 4'h8, 8'h00, 8'h0b, 1'b1, 1'b1, ZERO_BYTE, 1'b0);
		rx_case(1'b1, 8'h00, 2'h0, 1'b0, 8'h04, 1'b1);
		rx_case(1'b1, 8'h00, 2'h0, 1'b0, 8'h08, 1'b0);
		rx_case(1'b1, 8'h08, 2'h1, 1'b0, 8'h08, 1'b1);
		rx_case(1'b1, 8'h10, 2'h0, 1'b0, 8'h04, 1'b0);
		rx_case(1'b1, 8'h08, 2'h1, 1'b0, 8'h08, 1'b1);
		rx_case(1'b1, 8'h08, 2'h1, 1'b0, 8'h04, 1'b0);
		rx_case(1'b1, 8'h00, 2'h0, 1'b0, 8'h04, 1'b1);
		rx_case(1'b0, 8'h00, 2'h0, 1'b0, 8'h04, 1'b0);
		rx_case(1'b1, 8'h00, 2'h0, 1'b1, 8'h44, 1'b1);
		rx_case(1'b1, 8'h00, 2'h0, 1'b1, 8'h01, 1'b0);
		rx_case(1'b1, 8'h02, 2'h0, 1'b1, 8'h01, 1'b1);
		rx_case(1'b1, 8'h02, 2'h0, 1'b1, 8'h33, 1'b0);
		// Interrupt: raise, clear by read, mask
		wr(ADDR_IRQ_MASK, 8'h02);
		rd(ADDR_IRQ_STAT, d);
		rx_case(1'b1, 8'h00, 2'h0, 1'b0, 8'h04, 1'b1);
		chk_irq(1'b1);
		rd(ADDR_IRQ_STAT, d);
		`CHK("irq_stat", 8'h02, d & 8'h02)
		chk_irq(1'b0);
		wr(ADDR_IRQ_MASK, 8'h00);
		rx_case(1'b1, 8'h00, 2'h0, 1'b0, 8'h04, 1'b1);
		chk_irq(1'b0);
		wr(ADDR_IRQ_MASK, 8'h02);
		@(posedge sys_clk);
		chk_irq(1'b1);
		wr(ADDR_IRQ_MASK, 8'h04);
		rx_case(1'b1, 8'h00, 2'h0, 1'b1, 8'h44, 1'b1);
		chk_irq(1'b1);
		wr(ADDR_IRQ_MASK, 8'h01);
		rd(ADDR_IRQ_STAT, d);
		// Offset 100 loads position 106: wrap 2322 edges after the case returns
		tx_case(12'h064, 4'h8, 8'h00, 8'h09, 1'b1, 1'b0, 8'ha5, 1'b1);
		i = 0;
		#1;
		while (tx_frame_start !== 1'b1 && i < 2500) begin
			@(posedge sys_clk);
			#1;
			i++;
		end
		`CHK("frame_start_cyc", 2322, i)
		repeat (2) @(posedge sys_clk);
		chk_irq(1'b1);
		close_out();
	end
endmodule
`default_nettype wire
